// ===== rtl/sram_protocol_gpio_slave.sv
// 32-pin gpio behind a single-beat request/acknowledge back end
// assumes the adapter supplies clk, reset_n and one-cycle requests
// What this block does
// R1: all back-end signals sampled and driven on rising clk edges.
// R2: adapter forwards bus clock; block uses it directly.
// R3: adapter presents write fields then pulses write request one cycle.
// R4: write acknowledge is a single-cycle high pulse.
// R5: adapter holds chip enable across request through acknowledge.
// R6: adapter issues no new access before acknowledge.
// R7: adapter splits bursts into independent single transfers.
// R8: adapter presents read fields then pulses read request one cycle.
// R9: read acknowledge is a single-cycle high pulse.
// R10: retry replaces acknowledge; raised for accesses outside the map.
// R11: error only alongside an acknowledge; every location writable, so never raised.
// R12: timeout suppress held while an access is pending.
// R13: adapter reset is the block reset.
// R14: direction, output and input registers, each 32 bits.
// R15: acknowledge one cycle after request in the basic form.
// R16: read and write latency set independently by delay lines.
// R17: enabled pins driven from output register, others released.
// R18: input register returns live pin levels regardless of direction.
// R19: byte lane updates only with chip enable, write request, lane enable.
// R20: two locations: pin data and direction control.
// R21: base address parameter; decode relative to it.
// R22: reset clears direction and output registers, pins released.
// R23: read data valid with read acknowledge, zero otherwise.
`timescale 1ns/1ps
`default_nettype none
module sram_protocol_gpio_slave
    import gpio_pkg::*;
#(
    parameter logic [ADDR_W-1:0] BASE_ADDR = 32'h0000_0000,
    parameter int                RD_DELAY  = 1,
    parameter int                WR_DELAY  = 1,
    parameter int                PINS      = DATA_W
)
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // adapter back end
    input  wire logic [ADDR_W-1:0]   adapter_address,
    input  wire logic [LANES-1:0]    adapter_byte_enables,
    input  wire logic [DATA_W-1:0]   adapter_write_data,
    input  wire logic                write_request_pulse,
    input  wire logic                read_request_pulse,
    input  wire logic                transaction_chip_enable,
    output logic                     write_acknowledge_pulse,
    output logic                     read_acknowledge_pulse,
    output logic [DATA_W-1:0]        read_data,
    output logic                     peripheral_retry,
    output logic                     peripheral_error,
    output logic                     timeout_suppress,
    // pins
    input  wire logic [PINS-1:0]     pin_in,
    output logic [PINS-1:0]          pin_out,
    output logic [PINS-1:0]          pin_oe
);
    // R14: three 32-bit registers
    logic [DATA_W-1:0] dir_q;
    logic [DATA_W-1:0] out_q;
    wire  [DATA_W-1:0] dir_d;
    wire  [DATA_W-1:0] out_d;
    logic [PINS-1:0]   pin_meta_q;
    logic [PINS-1:0]   pin_sync_q;
    logic [RD_DELAY-1:0] rd_line_q;
    logic [WR_DELAY-1:0] wr_line_q;
    logic [ADDR_W-1:0] addr_q;
    logic              pend_q;
    logic [DATA_W-1:0] rdata_q;
    // tap one stage early so the data lands with the acknowledge
    localparam int     RD_PRE = (RD_DELAY > 1) ? RD_DELAY - 2 : 0;

    // R21: decode relative to base
    wire [ADDR_W-1:0] rel_addr  = (adapter_address - BASE_ADDR) & ADDR_MASK;
    wire [ADDR_W-1:0] rel_held  = (addr_q - BASE_ADDR) & ADDR_MASK;
    // R20: two locations
    wire              sel_data  = (rel_addr == PIN_DATA_OFF);
    wire              sel_dir   = (rel_addr == PIN_DIR_OFF);
    wire              held_data = (rel_held == PIN_DATA_OFF);
    wire              held_dir  = (rel_held == PIN_DIR_OFF);
    wire              held_hit  = held_data | held_dir;
    wire              wr_go     = transaction_chip_enable & write_request_pulse;
    wire              rd_go     = transaction_chip_enable & read_request_pulse;
    wire              rd_done   = rd_line_q[RD_DELAY-1];
    wire              wr_done   = wr_line_q[WR_DELAY-1];
    wire [PINS-1:0]   pin_level = pin_sync_q;
    wire [DATA_W-1:0] pin_word  = DATA_W'(pin_level);
    wire [DATA_W-1:0] rd_mux    = held_data ? pin_word : (held_dir ? dir_q : READ_IDLE);
    wire [DATA_W-1:0] rd_now    = sel_data ? pin_word : (sel_dir ? dir_q : READ_IDLE);
    // R23: data stands only in the acknowledge cycle
    wire              rd_next   = (RD_DELAY == 1) ? rd_go : rd_line_q[RD_PRE];
    wire [DATA_W-1:0] rdata_d   = rd_next ? ((RD_DELAY == 1) ? rd_now : rd_mux) : READ_IDLE;

    // R19: per-lane write strobes
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            wire lane_we = wr_go & adapter_byte_enables[g];
            assign dir_d[g*LANE_W +: LANE_W] = (lane_we && sel_dir) ?
                adapter_write_data[g*LANE_W +: LANE_W] : dir_q[g*LANE_W +: LANE_W];
            assign out_d[g*LANE_W +: LANE_W] = (lane_we && sel_data) ?
                adapter_write_data[g*LANE_W +: LANE_W] : out_q[g*LANE_W +: LANE_W];
        end
    endgenerate

    // R1: R22: rising-edge registers; pins released at reset
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dir_q <= DIR_RESET;
            out_q <= OUT_RESET;
        end
        else
        begin
            dir_q <= dir_d;
            out_q <= out_d;
        end
    end

    // R18: pins pass two flops, then read live
    // reads lag the pads by two clocks, the price of a metastability-safe input
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end
        else
        begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // R16: independent delay lines, depth 1 gives the basic form
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_line_q <= '0;
            wr_line_q <= '0;
            addr_q    <= '0;
            pend_q    <= 1'b0;
            rdata_q   <= READ_IDLE;
        end
        else
        begin
            // R15: shift request into acknowledge
            rd_line_q <= RD_DELAY'({rd_line_q, rd_go});
            wr_line_q <= WR_DELAY'({wr_line_q, wr_go});
            if (rd_go || wr_go)
                addr_q <= adapter_address;
            // R12: pending from request until answer
            if (rd_go || wr_go)
                pend_q <= 1'b1;
            else if (rd_done || wr_done)
                pend_q <= 1'b0;
            // R23: data only alongside read acknowledge
            rdata_q   <= rdata_d;
        end
    end

    // R4: R9: R10: acknowledge unless unmapped, then retry instead
    assign read_acknowledge_pulse  = rd_done & held_hit;
    assign write_acknowledge_pulse = wr_done & held_hit;
    assign peripheral_retry        = (rd_done | wr_done) & ~held_hit;
    // R11: no read-only location exists, so no access ends in error
    assign peripheral_error        = 1'b0;
    assign timeout_suppress        = pend_q & ~(rd_done | wr_done);
    assign read_data               = rdata_q;
    // R17: drive enabled pins only
    assign pin_oe  = dir_q[PINS-1:0];
    assign pin_out = out_q[PINS-1:0];

    // R4: R9: single-cycle acknowledges
    a_wr_ack_single: assert property (@(posedge clk) disable iff (!reset_n) // R4
        write_acknowledge_pulse |=> !write_acknowledge_pulse)
        else $error("write acknowledge longer than one cycle");
    a_rd_ack_single: assert property (@(posedge clk) disable iff (!reset_n) // R9
        read_acknowledge_pulse |=> !read_acknowledge_pulse)
        else $error("read acknowledge longer than one cycle");
    a_rd_latency: assert property (@(posedge clk) disable iff (!reset_n) // R15
        rd_go && (sel_data || sel_dir) && RD_DELAY == 1 |=> read_acknowledge_pulse)
        else $error("read acknowledge not one cycle after request");
    a_wr_latency: assert property (@(posedge clk) disable iff (!reset_n) // R16
        $past(wr_go, WR_DELAY) |-> write_acknowledge_pulse || peripheral_retry)
        else $error("write answer not at the write delay");
    a_rd_delay: assert property (@(posedge clk) disable iff (!reset_n) // R16
        $past(rd_go, RD_DELAY) |-> read_acknowledge_pulse || peripheral_retry)
        else $error("read answer not at the read delay");
    a_suppress_slow: assert property (@(posedge clk) disable iff (!reset_n) // R12
        (wr_go && WR_DELAY > 1) || (rd_go && RD_DELAY > 1) |=> timeout_suppress)
        else $error("timeout not suppressed on a slow access");
    a_retry_excl: assert property (@(posedge clk) disable iff (!reset_n) // R10
        peripheral_retry |-> !read_acknowledge_pulse && !write_acknowledge_pulse)
        else $error("retry together with acknowledge");
    a_data_idle: assert property (@(posedge clk) disable iff (!reset_n) // R23
        !read_acknowledge_pulse |-> read_data == READ_IDLE)
        else $error("read data not zero outside acknowledge");
    a_dir_write: assert property (@(posedge clk) disable iff (!reset_n) // R19
        wr_go && sel_dir && adapter_byte_enables[0] |=>
        dir_q[LANE_W-1:0] == $past(adapter_write_data[LANE_W-1:0]))
        else $error("direction lane 0 not written");
    a_hold_nowrite: assert property (@(posedge clk) disable iff (!reset_n) // R19
        !wr_go |=> $stable(out_q) && $stable(dir_q))
        else $error("register changed without write");
    a_pins_released: assert property (@(posedge clk) disable iff (!reset_n) // R22
        $rose(reset_n) |-> pin_oe == DIR_RESET[PINS-1:0])
        else $error("pins driven right after reset");
    a_out_write: assert property (@(posedge clk) disable iff (!reset_n) // R19
        wr_go && sel_data && adapter_byte_enables[0] |=>
        out_q[LANE_W-1:0] == $past(adapter_write_data[LANE_W-1:0]))
        else $error("output lane 0 not written");
    a_lane_masked: assert property (@(posedge clk) disable iff (!reset_n) // R19
        wr_go && sel_data && !adapter_byte_enables[1] |=> $stable(out_q[LANE_W +: LANE_W]))
        else $error("disabled output lane changed");
    a_unmapped_nowrite: assert property (@(posedge clk) disable iff (!reset_n) // R20
        wr_go && !sel_data && !sel_dir |=> $stable(out_q) && $stable(dir_q))
        else $error("unmapped write changed a register");
endmodule
`default_nettype wire

// ===== rtl/gpio_pkg.sv
// constants for the request/acknowledge gpio peripheral
// assumes a 32-bit adapter back end with four byte lanes
package gpio_pkg;
    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 32;
    localparam int          LANES        = 4;
    localparam int          LANE_W       = 8;
    // word offsets from the base address
    localparam logic [ADDR_W-1:0] PIN_DATA_OFF = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] PIN_DIR_OFF  = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] ADDR_MASK    = 32'hFFFF_FFFC;
    localparam logic [DATA_W-1:0] DIR_RESET    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OUT_RESET    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_IDLE    = 32'h0000_0000;
endpackage

// ===== tb/adapter_model.sv
// behavioural bus interface adapter on the gpio back end
// assumes the bench calls access() for one transfer at a time
`timescale 1ns/1ps
`default_nettype none
module adapter_model
    import gpio_pkg::*;
(
    // clock
    input  wire logic              clk,
    // requests
    output logic [ADDR_W-1:0]      adapter_address,
    output logic [LANES-1:0]       adapter_byte_enables,
    output logic [DATA_W-1:0]      adapter_write_data,
    output logic                   write_request_pulse,
    output logic                   read_request_pulse,
    output logic                   transaction_chip_enable,
    // answers
    input  wire logic              write_acknowledge_pulse,
    input  wire logic              read_acknowledge_pulse,
    input  wire logic [DATA_W-1:0] read_data,
    input  wire logic              peripheral_retry,
    input  wire logic              peripheral_error,
    input  wire logic              timeout_suppress
);
    initial
    begin
        {adapter_address, adapter_byte_enables, adapter_write_data} = '0;
        {write_request_pulse, read_request_pulse, transaction_chip_enable} = '0;
    end
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [LANES-1:0] be, input logic [DATA_W-1:0] d,
        output logic [DATA_W-1:0] rd, output logic rty, output int lat, output logic sup,
        output logic err);
        lat = 0;
        sup = 1'b0;
        @(posedge clk);
        adapter_address <= a;
        adapter_byte_enables <= be;
        adapter_write_data <= d;
        transaction_chip_enable <= 1'b1;
        write_request_pulse <= wr;
        read_request_pulse <= !wr;
        @(posedge clk);
        write_request_pulse <= 1'b0;
        read_request_pulse <= 1'b0;
        // chip enable held until ack or retry; bounded wait
        do
        begin
            @(posedge clk);
            lat++;
            sup |= timeout_suppress;
        end while (lat < 16 && !(write_acknowledge_pulse | read_acknowledge_pulse
            | peripheral_retry));
        rd = read_data;
        rty = peripheral_retry;
        // error is taken with the acknowledge
        err = peripheral_error;
        // released lines show the inverse so stale values never look valid
        transaction_chip_enable <= 1'b0;
        adapter_address <= ~a;
        adapter_write_data <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== tb/sram_protocol_gpio_slave_tb_top.sv
// bench for the gpio slave: table of accesses, then reset cases
// assumes adapter_model issues the back-end transfers
`timescale 1ns/1ps
`default_nettype none
module sram_protocol_gpio_slave_tb_top
    import gpio_pkg::*;
;
    localparam logic [ADDR_W-1:0] BASE = 32'h0000_1000;
    localparam int WR_LAT = 3;
    localparam logic [DATA_W-1:0] DH = 32'hFFFF_0000, DF = 32'hFFFF_FF00;
    localparam logic [DATA_W-1:0] OV = 32'h0034_0078, P1 = 32'hA5A5_A5A5;
    typedef struct packed {logic wr; logic [ADDR_W-1:0] a; logic [LANES-1:0] be;
        logic [DATA_W-1:0] d, pins, rd; logic rty; logic [DATA_W-1:0] oe, out;} row_s;
    row_s rows [8] = '{
        '{1'b1, BASE + PIN_DIR_OFF, 4'hF, DH, '0, '0, 1'b0, DH, '0},
        '{1'b1, BASE + PIN_DATA_OFF, 4'h5, 32'h1234_5678, '0, '0, 1'b0, DH, OV},
        '{1'b1, BASE + PIN_DIR_OFF, 4'h2, 32'h0000_FF00, '0, '0, 1'b0, DF, OV},
        '{1'b0, BASE + PIN_DIR_OFF, 4'hF, '0, '0, DF, 1'b0, DF, OV},
        '{1'b0, BASE + PIN_DATA_OFF, 4'hF, '0, P1, P1, 1'b0, DF, OV},
        '{1'b1, BASE + 32'h0000_0008, 4'hF, P1, P1, '0, 1'b1, DF, OV},
        '{1'b0, BASE + 32'h0000_000C, 4'hF, '0, ~P1, '0, 1'b1, DF, OV},
        '{1'b0, BASE + PIN_DATA_OFF, 4'h3, '0, ~P1, ~P1, 1'b0, DF, OV}};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [DATA_W-1:0] pin_in = '0;
    logic [ADDR_W-1:0] adapter_address;
    logic [LANES-1:0] adapter_byte_enables;
    logic [DATA_W-1:0] adapter_write_data, read_data, pin_out, pin_oe, rd;
    logic write_request_pulse, read_request_pulse, transaction_chip_enable, rty, sup, err;
    logic write_acknowledge_pulse, read_acknowledge_pulse, peripheral_retry;
    logic peripheral_error, timeout_suppress;
    int lat, mismatches = 0, checks_done = 0;
    always #10 clk = ~clk;
    sram_protocol_gpio_slave #(.BASE_ADDR(BASE), .WR_DELAY(WR_LAT)) u_sram_protocol_gpio_slave
        (.clk, .reset_n, .adapter_address, .adapter_byte_enables, .adapter_write_data,
        .write_request_pulse, .read_request_pulse, .transaction_chip_enable,
        .write_acknowledge_pulse, .read_acknowledge_pulse, .read_data, .peripheral_retry,
        .peripheral_error, .timeout_suppress, .pin_in, .pin_out, .pin_oe);
    adapter_model u_adapter_model (.clk, .adapter_address, .adapter_byte_enables,
        .adapter_write_data, .write_request_pulse, .read_request_pulse,
        .transaction_chip_enable, .write_acknowledge_pulse, .read_acknowledge_pulse,
        .read_data, .peripheral_retry, .peripheral_error, .timeout_suppress);
    task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic run(input logic wr, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] be,
        input logic [DATA_W-1:0] d);
        u_adapter_model.access(wr, a, be, d, rd, rty, lat, sup, err);
        check("latency", lat, wr ? WR_LAT : 1);
        check("suppress", 32'(sup), 32'(lat > 1));
        check("error", 32'(err), '0);
        if (lat >= 16)
        begin
            mismatches++;
            report_and_stop();
        end
        #1;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            pin_in <= rows[i].pins;
            repeat (3) @(posedge clk);
            run(rows[i].wr, rows[i].a, rows[i].be, rows[i].d);
            check("read data", rd, rows[i].rd);
            check("retry", 32'(rty), 32'(rows[i].rty));
            check("pin oe", pin_oe, rows[i].oe);
            check("pin out", pin_out, rows[i].out);
        end
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        #1;
        check("oe reset", pin_oe, DIR_RESET);
        check("out reset", pin_out, OUT_RESET);
        check("idle data", read_data, READ_IDLE);
        @(posedge clk);
        reset_n <= 1'b1;
        run(1'b0, BASE + PIN_DIR_OFF, 4'hF, '0);
        check("dir reset", rd, DIR_RESET);
        report_and_stop();
    end
endmodule
`default_nettype wire
